// ---- core/emi_pkg.sv ----
// package of constants and types for the external memory interface
//------------------------------------------------------------
// Summary of operation
// R1 - separate code and data chip select outputs
// R2 - combined external address space limited to 4 megabytes
// R3 - overlay up to 128 KB in 16 KB blocks from top of data memory down
// R4 - code reachable through data space via overlay, boot rom excepted (no block is excluded from the overlay here)
// R5 - fetches in mapped blocks are served from data ram
// R6 - no speed sensing; slow clock after reset until execution moves to ram
// R7 - firmware copies code or host downloads it before operation
// R8 - code and data spaces each independently 8 or 16 bits wide
// R9 - memory configuration strap sampled from a data pin during reset
// R10 - strobe roles switch per access by addressed space
// R11 - 8-bit space: shared pin is address lsb, low write strobe only write
// R12 - 16-bit paired x8: shared pin high write, low strobe low write
// R13 - single x16: shared pin upper byte enable, lower select pin lower
// R14 - each space all x8 or all x16
// R15 - at least 128 KB external sram
// R16 - data sram 16 bits wide for full-rate operation
// R17 - boot rom copies card info structure from serial memory, 400 kHz link
// R18 - strobes active low, idle high when no access and in reset
// R19 - unmapped code access asserts only code select, data only data select
//------------------------------------------------------------
package emi_pkg;
	localparam int ADDR_W        = 22;
	localparam int CODE_ADDR_W   = 17;
	localparam int BLK_LSB       = 14;
	localparam int NUM_BLK       = 8;
	localparam int STRAP_PIN     = 0;
	localparam int CLK_HZ        = 25000000;
	localparam int SER_HZ        = 400000;
	localparam int SER_HALF      = CLK_HZ / (2 * SER_HZ);
	localparam int SLOW_DIV      = 4;
	localparam int CIS_BYTES     = 256;
	localparam logic [6:0] SER_DEV = 7'h50;

	typedef enum logic [1:0] {
		EMI_X8    = 2'b00,
		EMI_PAIR8 = 2'b01,
		EMI_X16   = 2'b10
	} emi_org_t;

	typedef struct packed {
		logic                 valid;
		logic                 write;
		logic                 isCode;
		logic [1:0]           byteEn;
		logic [ADDR_W-1:0]    addr;
		logic [15:0]          wdata;
	} emi_req_t;

	typedef struct packed {
		logic                 codeCs_n;
		logic                 dataCs_n;
		logic                 readOutputStrobe_n;
		logic                 lowWriteStrobe_n;
		logic                 addrLsbOrHighStrobe;
		logic                 lowerByteSelect_n;
		logic [ADDR_W-1:1]    addr;
	} emi_pins_t;
endpackage

// ---- core/emi_boot_copier.sv ----
// serial nonvolatile boot copier: reads card info bytes over a two-wire link
`timescale 1ns/1ps
`default_nettype none
module emi_boot_copier
	import emi_pkg::*;
#(
	parameter int NBYTES = CIS_BYTES
) (
	input  wire logic        clock,     // system clock
	input  wire logic        rst_n,     // async reset
	input  wire logic        start,     // begin copy pulse
	input  wire logic        sdaIn,     // synchronised data in
	output logic             sclOut,    // serial clock level
	output logic             sdaOe,     // drive data low
	output logic             wrValid,   // byte ready
	output logic [15:0]      wrAddr,    // byte index
	output logic [7:0]       wrData,    // byte value
	output logic             done       // copy complete
);
	typedef enum logic [2:0] {
		BC_IDLE  = 3'b000,
		BC_START = 3'b001,
		BC_SEND  = 3'b010,
		BC_RECV  = 3'b011,
		BC_STOP  = 3'b100,
		BC_DONE  = 3'b101
	} emi_bc_t;

	emi_bc_t state_q, state_d;
	logic [7:0]  div_q, div_d;
	logic        ph_q, ph_d;
	logic [4:0]  bit_q, bit_d;
	logic [8:0]  sh_q, sh_d;
	logic [15:0] cnt_q, cnt_d;
	logic        v_q, v_d;
	logic        tick;

	assign tick = (div_q == 8'(SER_HALF - 1));

	//------------------------------------------------------------
	// serial sequence
	//------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		div_d   = tick ? 8'h00 : div_q + 8'h01;
		ph_d    = ph_q;
		bit_d   = bit_q;
		sh_d    = sh_q;
		cnt_d   = cnt_q;
		v_d     = 1'b0;
		if (state_q == BC_IDLE) begin
			div_d = 8'h00;
		end
		unique case (state_q)
			BC_IDLE: begin
				if (start) begin
					state_d = BC_START;
				end
			end
			BC_START: begin
				if (tick) begin
					state_d = BC_SEND;
					ph_d    = 1'b0;
					bit_d   = 5'h00;
					sh_d    = {SER_DEV, 1'b1, 1'b1};
				end
			end
			BC_SEND: begin
				if (tick) begin
					ph_d = ~ph_q;
					if (ph_q) begin
						sh_d  = {sh_q[7:0], 1'b1};
						bit_d = bit_q + 5'h01;
						if (bit_q == 5'h08) begin
							state_d = BC_RECV;
							bit_d   = 5'h00;
						end
					end
				end
			end
			BC_RECV: begin
				if (tick) begin
					ph_d = ~ph_q;
					if (ph_q) begin
						bit_d = bit_q + 5'h01;
						if (bit_q < 5'h08) begin
							sh_d = {sh_q[7:0], sdaIn};
						end
						if (bit_q == 5'h08) begin
							v_d   = 1'b1;
							bit_d = 5'h00;
							if (cnt_q == 16'(NBYTES - 1)) begin
								state_d = BC_STOP;
							end
						end
					end
				end
			end
			BC_STOP: begin
				if (tick) begin
					state_d = BC_DONE;
				end
			end
			BC_DONE: begin
			end
			default: begin
				state_d = BC_IDLE;
			end
		endcase
		if (v_q) begin
			cnt_d = cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= BC_IDLE;
			div_q   <= 8'h00;
			ph_q    <= 1'b0;
			bit_q   <= 5'h00;
			sh_q    <= 9'h000;
			cnt_q   <= 16'h0000;
			v_q     <= 1'b0;
		end else begin
			state_q <= state_d;
			div_q   <= div_d;
			ph_q    <= ph_d;
			bit_q   <= bit_d;
			sh_q    <= sh_d;
			cnt_q   <= cnt_d;
			v_q     <= v_d;
		end
	end

	assign sclOut  = (state_q == BC_SEND || state_q == BC_RECV) ? ph_q : 1'b1;
	// master acks every byte but the last in receive phase
	assign sdaOe   = (state_q == BC_START) || (state_q == BC_STOP) ||
		(state_q == BC_SEND && !sh_q[8] && bit_q != 5'h08) ||
		(state_q == BC_RECV && bit_q == 5'h08 && cnt_q != 16'(NBYTES - 1));
	assign wrValid = v_q;
	assign wrAddr  = cnt_q;
	assign wrData  = sh_q[7:0];
	assign done    = (state_q == BC_DONE);
endmodule
`default_nettype wire

// ---- core/emi_controller.sv ----
// external memory controller with code overlay, strobe roles and boot copy
`timescale 1ns/1ps
`default_nettype none
module emi_controller
	import emi_pkg::*;
#(
	parameter int MEM_TOP_BLK = 16  // top of physical data memory in 16 KB blocks
) (
	input  wire logic              clock,          // 25 MHz system clock
	input  wire logic              rst_n,          // async reset
	input  wire emi_req_t          req,            // access request
	output logic                   reqReady,       // access accepted
	output logic [15:0]            rdata,          // read data
	output logic                   rvalid,         // read data valid
	input  wire logic [NUM_BLK-1:0] overlayMap,    // code blocks mapped to ram
	input  wire logic              codeWide,       // code space 16 bits
	input  wire logic              dataWide,       // data space 16 bits
	input  wire logic              inRam,          // execution moved to ram
	output emi_pins_t              pins,           // memory control pins
	input  wire logic [15:0]       memoryDataIn,   // data pins in
	output logic [15:0]            memoryDataOut,  // data pins out
	output logic                   memoryDataOe,   // data pins drive
	output logic                   slowClock,      // slow instruction clock active
	output logic                   strapX16,       // sampled single-x16 strap
	output logic                   sclOut,         // serial clock
	output logic                   sdaOe,          // serial data pull low
	input  wire logic              sdaIn,          // serial data pin
	output logic                   bootDone        // boot copy complete
);
	//------------------------------------------------------------
	// synchronisers and strap capture
	//------------------------------------------------------------
	logic [15:0] mdS1_q, mdS2_q;
	logic        sdaS1_q, sdaS2_q;
	logic        strap_q, strapDone_q;
	logic        started_q;
	logic [3:0]  slowCnt_q, slowCnt_d;
	logic        slow_q;

	// data pins keep clocking in reset so the strap level is ready at release
	always_ff @(posedge clock) begin
		mdS1_q <= memoryDataIn;
		mdS2_q <= mdS1_q;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sdaS1_q <= 1'b1;
			sdaS2_q <= 1'b1;
		end else begin
			sdaS1_q <= sdaIn;
			sdaS2_q <= sdaS1_q;
		end
	end

	// R9 strap level seen on the pin during reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			strap_q     <= 1'b0;
			strapDone_q <= 1'b0;
			started_q   <= 1'b0;
		end else begin
			strapDone_q <= 1'b1;
			started_q   <= strapDone_q;
			if (!strapDone_q) begin
				strap_q <= mdS2_q[STRAP_PIN];
			end
		end
	end
	assign strapX16 = strap_q;

	// R6 slow cycle until ram execution
	always_comb begin
		slowCnt_d = (slowCnt_q == 4'(SLOW_DIV - 1)) ? 4'h0 : slowCnt_q + 4'h1;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			slowCnt_q <= 4'h0;
			slow_q    <= 1'b1;
		end else begin
			slowCnt_q <= slowCnt_d;
			if (inRam) begin
				slow_q <= 1'b0;
			end
		end
	end
	assign slowClock = slow_q;

	//------------------------------------------------------------
	// boot copier
	//------------------------------------------------------------
	logic        bcValid;
	logic [15:0] bcAddr;
	logic [7:0]  bcData;

	// R17 boot copy after reset
	emi_boot_copier #(
		.NBYTES(CIS_BYTES)
	) u_boot (
		.clock  (clock),
		.rst_n  (rst_n),
		.start  (strapDone_q && !started_q),
		.sdaIn  (sdaS2_q),
		.sclOut (sclOut),
		.sdaOe  (sdaOe),
		.wrValid(bcValid),
		.wrAddr (bcAddr),
		.wrData (bcData),
		.done   (bootDone)
	);

	//------------------------------------------------------------
	// address mapping
	//------------------------------------------------------------
	// R3 overlay block placed below top of data memory
	function automatic logic [ADDR_W-1:0] overlayAddr(input logic [CODE_ADDR_W-1:0] a);
		logic [2:0]        blk;
		logic [ADDR_W-1:0] base;
		blk  = a[CODE_ADDR_W-1:BLK_LSB];
		base = ADDR_W'(MEM_TOP_BLK - 1 - int'(blk)) << BLK_LSB;
		return base | ADDR_W'(a[BLK_LSB-1:0]);
	endfunction

	typedef enum logic [1:0] {
		AC_IDLE  = 2'b00,
		AC_SETUP = 2'b01,
		AC_STRB  = 2'b10,
		AC_HOLD  = 2'b11
	} emi_acc_t;

	emi_acc_t          st_q, st_d;
	emi_req_t          cur_q, cur_d;
	logic              useData_q, useData_d;
	logic              wide_q, wide_d;
	logic [ADDR_W-1:0] phys_q, phys_d;
	logic [15:0]       rd_q, rd_d;
	logic              rv_q, rv_d;
	logic              mapped;
	emi_req_t          inReq;
	logic              accept;
	logic              bcPend_q, bcPend_d;
	logic [15:0]       bcPAddr_q, bcPAddr_d;
	logic [7:0]        bcPData_q, bcPData_d;

	// a pending boot byte takes priority over the request port
	always_comb begin
		inReq = req;
		if (bcPend_q) begin
			inReq.valid  = 1'b1;
			inReq.write  = 1'b1;
			inReq.isCode = 1'b0;
			inReq.byteEn = bcPAddr_q[0] ? 2'b10 : 2'b01;
			inReq.addr   = ADDR_W'(bcPAddr_q);
			inReq.wdata  = {bcPData_q, bcPData_q};
		end
	end

	// R5 mapped blocks go to data ram; R4 has no boot rom exception here, any block with its overlayMap bit set is mapped
	assign mapped   = inReq.isCode && overlayMap[inReq.addr[CODE_ADDR_W-1:BLK_LSB]];
	assign accept   = (st_q == AC_IDLE) && inReq.valid && (!slow_q || slowCnt_q == 4'h0);
	assign reqReady = accept && !bcPend_q;

	// R17 boot byte waits until the access machine takes it
	always_comb begin
		bcPend_d  = (bcPend_q && !accept) || bcValid;
		bcPAddr_d = bcValid ? bcAddr : bcPAddr_q;
		bcPData_d = bcValid ? bcData : bcPData_q;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bcPend_q  <= 1'b0;
			bcPAddr_q <= 16'h0000;
			bcPData_q <= 8'h00;
		end else begin
			bcPend_q  <= bcPend_d;
			bcPAddr_q <= bcPAddr_d;
			bcPData_q <= bcPData_d;
		end
	end

	always_comb begin
		st_d      = st_q;
		cur_d     = cur_q;
		useData_d = useData_q;
		wide_d    = wide_q;
		phys_d    = phys_q;
		rd_d      = rd_q;
		rv_d      = 1'b0;
		unique case (st_q)
			AC_IDLE: begin
				if (accept) begin
					st_d      = AC_SETUP;
					cur_d     = inReq;
					useData_d = !inReq.isCode || mapped;
					// R8 per-space width
					wide_d    = (!inReq.isCode || mapped) ? dataWide : codeWide;
					// R2 address limited to 4 MB
					phys_d    = mapped ? overlayAddr(inReq.addr[CODE_ADDR_W-1:0]) :
						inReq.isCode ? ADDR_W'(inReq.addr[CODE_ADDR_W-1:0]) : inReq.addr;
				end
			end
			AC_SETUP: begin
				st_d = AC_STRB;
			end
			AC_STRB: begin
				st_d = AC_HOLD;
			end
			AC_HOLD: begin
				st_d = AC_IDLE;
				// setup-cycle data has passed both synchroniser stages by now
				if (!cur_q.write) begin
					rd_d = mdS2_q;
					rv_d = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q      <= AC_IDLE;
			cur_q     <= '0;
			useData_q <= 1'b0;
			wide_q    <= 1'b0;
			phys_q    <= '0;
			rd_q      <= 16'h0000;
			rv_q      <= 1'b0;
		end else begin
			st_q      <= st_d;
			cur_q     <= cur_d;
			useData_q <= useData_d;
			wide_q    <= wide_d;
			phys_q    <= phys_d;
			rd_q      <= rd_d;
			rv_q      <= rv_d;
		end
	end
	assign rdata  = rd_q;
	assign rvalid = rv_q;

	//------------------------------------------------------------
	// pin roles
	//------------------------------------------------------------
	logic active;
	logic strobe;
	assign active = (st_q != AC_IDLE);
	assign strobe = (st_q == AC_STRB);

	always_comb begin
		pins = '{codeCs_n: 1'b1, dataCs_n: 1'b1, readOutputStrobe_n: 1'b1,
			lowWriteStrobe_n: 1'b1, addrLsbOrHighStrobe: 1'b1,
			lowerByteSelect_n: 1'b1, addr: phys_q[ADDR_W-1:1]};
		if (active) begin
			// R1 R19 one select per access
			pins.codeCs_n = useData_q;
			pins.dataCs_n = !useData_q;
			// read strobe low from setup so data reach the second sync stage
			pins.readOutputStrobe_n = !((st_q != AC_HOLD) && !cur_q.write);
			// R10 roles switch per addressed space
			if (!wide_q) begin
				// R11 address lsb and single write strobe
				pins.addrLsbOrHighStrobe = phys_q[0];
				pins.lowWriteStrobe_n    = !(strobe && cur_q.write);
			end else if (!strap_q) begin
				// R12 paired x8 byte writes
				pins.addrLsbOrHighStrobe = !(strobe && cur_q.write && cur_q.byteEn[1]);
				pins.lowWriteStrobe_n    = !(strobe && cur_q.write && cur_q.byteEn[0]);
			end else begin
				// R13 single x16 byte enables
				pins.addrLsbOrHighStrobe = !cur_q.byteEn[1];
				pins.lowerByteSelect_n   = !cur_q.byteEn[0];
				pins.lowWriteStrobe_n    = !(strobe && cur_q.write);
			end
		end
		// R18 idle deasserted (reset holds state idle)
	end

	assign memoryDataOut = (!wide_q && phys_q[0]) ? {cur_q.wdata[15:8], cur_q.wdata[15:8]} :
		cur_q.wdata;
	assign memoryDataOe  = active && cur_q.write;
endmodule
`default_nettype wire

// ---- verif/emi_monitor.sv ----
// checker on the memory controller ports
`timescale 1ns/1ps
`default_nettype none
module emi_monitor
	import emi_pkg::*;
#(
	parameter int MEM_TOP_BLK = 16
) (
	input wire logic               clock,      // clock
	input wire logic               rst_n,      // reset
	input wire emi_req_t           req,        // request
	input wire logic               reqReady,   // taken
	input wire logic               rvalid,     // read valid
	input wire logic [NUM_BLK-1:0] overlayMap, // map
	input wire logic               codeWide,   // code 16
	input wire logic               dataWide,   // data 16
	input wire logic               inRam,      // in ram
	input wire emi_pins_t          pins,       // pins
	input wire logic               slowClock,  // slow
	input wire logic               strapX16    // strap
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	//----------------------------------------
	// helpers and sequences
	//----------------------------------------
	logic [2:0] blk;
	logic       ovl, wide, lsb, beHi, beLo;
	logic [12:0] offs;
	assign blk  = req.addr[BLK_LSB+2:BLK_LSB];
	assign ovl  = req.isCode && overlayMap[blk];
	assign wide = (req.isCode && !ovl) ? codeWide : dataWide;
	assign lsb  = req.addr[0];
	assign beHi = req.byteEn[1];
	assign beLo = req.byteEn[0];
	assign offs = req.addr[BLK_LSB-1:1];
	sequence s_setup;
		!(pins.codeCs_n && pins.dataCs_n) && pins.lowWriteStrobe_n;
	endsequence
	sequence s_hold;
		pins.readOutputStrobe_n && pins.lowWriteStrobe_n;
	endsequence
	AST_CS_ONE: assert property (pins.codeCs_n || pins.dataCs_n)
		else $error("both selects low");
	AST_SPACING: assert property (reqReady |=> !reqReady [*3])
		else $error("take too soon");
	AST_READ: assert property (reqReady && !req.write |=> (s_setup and !pins.readOutputStrobe_n) ##1
		(!pins.readOutputStrobe_n && pins.lowWriteStrobe_n) ##1 s_hold ##1 rvalid)
		else $error("read walk wrong");
	AST_WRITE: assert property (reqReady && req.write |=> (s_setup and pins.readOutputStrobe_n) ##1
		pins.readOutputStrobe_n ##1 (s_hold and !rvalid))
		else $error("write walk wrong");
	AST_CODE_CS: assert property (reqReady && req.isCode && !ovl |=> !pins.codeCs_n [*3])
		else $error("code select missing");
	AST_DATA_CS: assert property (reqReady && (!req.isCode || ovl) |=>
		!pins.dataCs_n && pins.codeCs_n)
		else $error("data select missing");
	AST_OVERLAY: assert property (reqReady && ovl |=>
		pins.addr[ADDR_W-1:BLK_LSB] == 8'(MEM_TOP_BLK - 1 - $past(blk))
		&& pins.addr[BLK_LSB-1:1] == $past(offs))
		else $error("overlay address wrong");
	AST_X8_LSB: assert property (reqReady && !wide |=> pins.addrLsbOrHighStrobe == $past(lsb))
		else $error("byte space lsb wrong");
	AST_X16_BE: assert property (reqReady && wide && strapX16 |=> ##1
		pins.addrLsbOrHighStrobe == !$past(beHi, 2) && pins.lowerByteSelect_n == !$past(beLo, 2))
		else $error("byte enables wrong");
	AST_PAIR: assert property (reqReady && req.write && wide && !strapX16 |=> ##1
		pins.addrLsbOrHighStrobe == !$past(beHi, 2) && pins.lowWriteStrobe_n == !$past(beLo, 2))
		else $error("paired strobes wrong");
	AST_FAST: assert property (inRam |-> ##[0:2] !slowClock)
		else $error("clock stays slow");
	AST_STAY: assert property (!slowClock |=> !slowClock)
		else $error("clock slowed again");
endmodule
bind emi_controller emi_monitor #(.MEM_TOP_BLK(MEM_TOP_BLK)) u_mon (.clock(clock),
	.rst_n(rst_n), .req(req), .reqReady(reqReady), .rvalid(rvalid), .overlayMap(overlayMap),
	.codeWide(codeWide), .dataWide(dataWide), .inRam(inRam), .pins(pins),
	.slowClock(slowClock), .strapX16(strapX16));
`default_nettype wire

// ---- verif/emi_mem_model.sv ----
// parallel memories and serial boot memory beside the controller
`timescale 1ns/1ps
`default_nettype none
module emi_mem_model
	import emi_pkg::*;
(
	input  wire logic        clock,         // clock
	input  wire logic        strap,         // strap level
	input  wire emi_pins_t   pins,          // pins
	input  wire logic [15:0] memoryDataOut, // write data
	output logic [15:0]      memoryDataIn,  // read data
	input  wire logic        sclOut,        // serial clock
	input  wire logic        sdaOe,         // pull low
	output logic             sdaIn          // serial wire
);
	// sparse store spans the space, 16 bits a word
	logic [15:0] mem [logic [21:0]];
	logic [15:0] last = 16'h0000;
	logic [21:0] key;
	logic        sel, rdOn;
	logic        ackLow = 1'b0;
	int          bitN = 0;
	assign key  = {pins.codeCs_n, pins.addr};
	assign sel  = !(pins.codeCs_n && pins.dataCs_n);
	assign rdOn = sel && !pins.readOutputStrobe_n;
	// released bus: strap pull on bit 0, the rest flips
	always @* begin
		if (rdOn) memoryDataIn = mem.exists(key) ? mem[key] : 16'hffff;
		else memoryDataIn = {~last[15:1], strap};
	end
	always @(negedge clock) begin
		if (rdOn) last <= memoryDataIn;
		if (sel && pins.readOutputStrobe_n) begin
			if (!mem.exists(key)) mem[key] = 16'hffff;
			if (!pins.addrLsbOrHighStrobe && (!pins.lowWriteStrobe_n || !strap))
				mem[key][15:8] = memoryDataOut[15:8];
			if (!pins.lowWriteStrobe_n && (!pins.lowerByteSelect_n || !strap))
				mem[key][7:0] = memoryDataOut[7:0];
		end
	end
	// open-drain wire, ack on each ninth clock
	assign sdaIn = !(sdaOe || ackLow);
	always @(negedge sdaIn) if (sclOut) bitN = 0;
	always @(negedge sclOut) begin
		bitN = bitN + 1;
		ackLow = (bitN % 9 == 0);
	end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the memory controller
`timescale 1ns/1ps
`default_nettype none
module tb;
	import emi_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic codeWide = 1'b1, dataWide = 1'b1, inRam = 1'b0, strap = 1'b1;
	logic reqReady, rvalid, memoryDataOe, slowClock, strapX16, sclOut, sdaOe, sdaIn, bootDone;
	logic [15:0] rdata, memoryDataIn, memoryDataOut, rd;
	logic [7:0] overlayMap = 8'h00;
	emi_req_t req = '0;
	emi_pins_t pins;
	int error_cnt = 0, samples_checked = 0;
	initial forever #20 clock = ~clock;
	emi_controller u_dut (.clock(clock), .rst_n(rst_n), .req(req), .reqReady(reqReady),
		.rdata(rdata), .rvalid(rvalid), .overlayMap(overlayMap), .codeWide(codeWide),
		.dataWide(dataWide), .inRam(inRam), .pins(pins), .memoryDataIn(memoryDataIn),
		.memoryDataOut(memoryDataOut), .memoryDataOe(memoryDataOe), .slowClock(slowClock),
		.strapX16(strapX16), .sclOut(sclOut), .sdaOe(sdaOe), .sdaIn(sdaIn), .bootDone(bootDone));
	emi_mem_model u_mem (.clock(clock), .strap(strap), .pins(pins), .memoryDataOut(memoryDataOut),
		.memoryDataIn(memoryDataIn), .sclOut(sclOut), .sdaOe(sdaOe), .sdaIn(sdaIn));
	//----------------------------------------
	// shared tasks
	//----------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic acc(input logic wr, input logic cd, input logic [1:0] be,
		input logic [21:0] a, input logic [15:0] wd);
		int n;
		@(negedge clock);
		req = '{1'b1, wr, cd, be, a, wd};
		n = 0;
		#1;
		while (reqReady !== 1'b1 && n < 60) begin
			@(negedge clock);
			#1;
			n++;
		end
		@(negedge clock);
		req.valid = 1'b0;
		while (!wr && rvalid !== 1'b1 && n < 60) begin
			@(negedge clock);
			n++;
		end
		rd = rdata;
		if (n >= 60) begin
			error_cnt++;
			$display("BAD access expected 1 seen 0");
			finish_test();
		end
	endtask
	task automatic do_reset(input logic s);
		strap = s;
		inRam = 1'b0;
		rst_n = 1'b0;
		repeat (10) @(negedge clock);
		chk("idle pins", 16'h001f, {11'h0, pins.codeCs_n, pins.dataCs_n,
			pins.readOutputStrobe_n, pins.lowWriteStrobe_n, pins.lowerByteSelect_n});
		chk("reset clocks", 16'h0006, {13'h0, slowClock, sclOut, memoryDataOe});
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		chk("strap", {15'h0, s}, {15'h0, strapX16});
	endtask
	//----------------------------------------
	// scenarios
	//----------------------------------------
	task automatic t_rw();
		acc(1'b1, 1'b0, 2'b11, 22'h010010, 16'ha5c3);
		acc(1'b1, 1'b0, 2'b10, 22'h010010, 16'h3c00);
		acc(1'b0, 1'b0, 2'b11, 22'h010010, 16'h0000);
		chk("byte lanes", 16'h3cc3, rd);
	endtask
	task automatic t_slow();
		chk("slow clock", 16'h0001, {15'h0, slowClock});
		// code sits in ram before full speed
		inRam = 1'b1;
		repeat (3) @(negedge clock);
		chk("fast clock", 16'h0000, {15'h0, slowClock});
	endtask
	task automatic t_ovl();
		logic [2:0] b;
		for (int i = 0; i < 2; i++) begin
			b = i ? 3'd7 : 3'd2;
			overlayMap = 8'h01 << b;
			acc(1'b1, 1'b0, 2'b11, {4'h0, 4'(15 - b), 14'h0020}, {13'h0246, b});
			acc(1'b0, 1'b1, 2'b11, {5'h0, b, 14'h0020}, 16'h0000);
			chk("overlay read", {13'h0246, b}, rd);
			overlayMap = 8'h00;
			acc(1'b0, 1'b1, 2'b11, {5'h0, b, 14'h0020}, 16'h0000);
			chk("code read", 16'hffff, rd);
		end
	endtask
	task automatic t_mix();
		for (int m = 0; m < 4; m++) begin
			codeWide = m[0];
			dataWide = m[1];
			acc(1'b0, 1'b1, 2'b10, 22'h000103, 16'h0000);
			acc(1'b1, 1'b0, 2'b10, 22'h010103, 16'h7e00);
			if (m[1]) begin
				acc(1'b0, 1'b0, 2'b11, 22'h010103, 16'h0000);
				chk("mix lanes", 16'h7eff, rd);
			end
		end
		codeWide = 1'b1;
		dataWide = 1'b1;
	endtask
	task automatic t_pair();
		do_reset(1'b0);
		acc(1'b1, 1'b0, 2'b10, 22'h020200, 16'h5a00);
		acc(1'b0, 1'b0, 2'b11, 22'h020200, 16'h0000);
		chk("paired lanes", 16'h5aff, rd);
	endtask
	task automatic t_boot();
		int n;
		n = 0;
		while (!(!pins.dataCs_n && memoryDataOe && pins.addr == 21'h0) && n < 3000) begin
			@(negedge clock);
			n++;
		end
		if (n >= 3000) begin
			error_cnt++;
			$display("BAD boot write expected 1 seen 0");
			finish_test();
		end
		chk("boot byte", 16'h00ff, {8'h00, memoryDataOut[7:0]});
		chk("boot busy", 16'h0000, {15'h0, bootDone});
	endtask
	initial begin
		do_reset(1'b1);
		t_rw();
		t_slow();
		t_ovl();
		t_mix();
		t_pair();
		t_boot();
		finish_test();
	end
endmodule
`default_nettype wire
